/* hdl/wtc_top.sv */
// Wide 18-bit timer/counter with APB register file
`timescale 1ns/1ps
`include "wtc_defs.svh"
module wtc_top
   import wtc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic low_freq_clock_pin,
   input wire logic event_pin,
   output logic irq
);
   // ----------------------------------------
   // Address decode helper
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
      hit = (addr == off);
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [1:0] run_reg;
   logic [2:0] src_reg;
   logic [1:0] mode_reg;
   logic [3:0] ctrl2_reg;
   logic [`WTC_CNT_W-1:0] cmp_reg;
   logic armed_reg;
   logic [7:0] gate_reg;
   logic [`WTC_CNT_W-1:0] cnt_reg;
   logic [`WTC_CNT_W-1:0] cnt_next;
   logic ovf_reg;
   logic [`WTC_IRQ_W-1:0] irq_stat_reg;
   logic [`WTC_IRQ_W-1:0] irq_stat_next;
   logic [`WTC_IRQ_W-1:0] irq_mask_reg;
   logic irq_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic [1:0] fs_sync_reg;
   logic [1:0] ev_sync_reg;
   logic fs_prev_reg;
   logic ev_prev_reg;
   logic gate_prev_reg;
   logic match_evt;
   logic ovf_evt;
   logic done_evt;
   logic [31:0] rdata;

   // ----------------------------------------
   // Pin synchronisers and edges
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fs_sync_reg <= 2'b00;
         ev_sync_reg <= 2'b00;
         fs_prev_reg <= 1'b0;
         ev_prev_reg <= 1'b0;
      end else begin
         fs_sync_reg <= {fs_sync_reg[0], low_freq_clock_pin};
         ev_sync_reg <= {ev_sync_reg[0], event_pin};
         fs_prev_reg <= fs_sync_reg[1];
         ev_prev_reg <= ev_sync_reg[1];
      end
   end

   wire fs_tick = fs_sync_reg[1] & ~fs_prev_reg;
   wire ev_level = ev_sync_reg[1];
   wire ev_fall = ~ev_sync_reg[1] & ev_prev_reg;
   wire ev_rise = ev_sync_reg[1] & ~ev_prev_reg;

   // ----------------------------------------
   // Prescalers on the fast and slow clocks
   // ----------------------------------------
   wire [`WTC_PRE_W:0] fc_tap;
   wire [`WTC_PRE_W:0] fs_tap;

   wtc_prescaler u_fc_pre (
      .pclk(pclk),
      .presetn(presetn),
      .step(1'b1),
      .tick(fc_tap)
   );

   wtc_prescaler u_fs_pre (
      .pclk(pclk),
      .presetn(presetn),
      .step(fs_tick),
      .tick(fs_tap)
   );

   // ----------------------------------------
   // Source clock selection
   // ----------------------------------------
   wire use_fs = ctrl2_reg[`WTC_DIVOPT_BIT] | ctrl2_reg[`WTC_SLOW_BIT];
   wire tap_long = use_fs ? fs_tap[15] : fc_tap[23];
   wire tap_mid = use_fs ? fs_tap[5] : fc_tap[13];
   wire tap_short = use_fs ? fs_tap[3] : fc_tap[11];
   logic src_tick;

   always_comb begin
      case (src_reg)
         3'b000: src_tick = fc_tap[0];
         3'b001: src_tick = fs_tap[0];
         3'b010: src_tick = tap_long;
         3'b011: src_tick = tap_mid;
         3'b100: src_tick = tap_short;
         3'b101: src_tick = fc_tap[7];
         3'b110: src_tick = fc_tap[3];
         default: src_tick = ev_fall;
      endcase
   end

   // ----------------------------------------
   // Window gate pulse
   // ----------------------------------------
   wire [1:0] gsrc = ctrl2_reg[`WTC_GSRC_HI:`WTC_GSRC_LO];
   logic gate_tick;

   always_comb begin
      case (gsrc)
         2'b00: gate_tick = use_fs ? fs_tap[4] : fc_tap[12];
         2'b01: gate_tick = use_fs ? fs_tap[5] : fc_tap[13];
         2'b10: gate_tick = use_fs ? fs_tap[6] : fc_tap[14];
         default: gate_tick = 1'b0;
      endcase
   end

   wire running = (run_reg == WTC_RUN_START);
   wire mode_freq = (wtc_mode_t'(mode_reg) == WTC_MODE_FREQ);
   wire gate_level;

   wtc_gate_gen u_gate (
      .pclk(pclk),
      .presetn(presetn),
      .enable(running & mode_freq),
      .tick(gate_tick),
      .high_set(gate_reg[7:4]),
      .low_set(gate_reg[3:0]),
      .gate(gate_level)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_prev_reg <= 1'b0;
      end else begin
         gate_prev_reg <= gate_level;
      end
   end

   wire gate_rise = gate_level & ~gate_prev_reg;
   wire gate_fall = ~gate_level & gate_prev_reg;

   // ----------------------------------------
   // APB access decode
   // ----------------------------------------
   wire access_start = psel & penable & ~pready_reg;
   wire wr_fire = psel & penable & pready_reg & pwrite;
   wire sel_ctrl1 = hit(paddr, `WTC_OFF_CTRL1);
   wire sel_low = hit(paddr, `WTC_OFF_CMP_LOW);
   wire sel_mid = hit(paddr, `WTC_OFF_CMP_MID);
   wire sel_top = hit(paddr, `WTC_OFF_CMP_TOP);
   wire sel_gate = hit(paddr, `WTC_OFF_GATE);
   wire sel_ctrl2 = hit(paddr, `WTC_OFF_CTRL2);
   wire sel_status = hit(paddr, `WTC_OFF_STATUS);
   wire sel_istat = hit(paddr, `WTC_OFF_IRQ_STAT);
   wire sel_imask = hit(paddr, `WTC_OFF_IRQ_MASK);
   wire addr_ok = sel_ctrl1 | sel_low | sel_mid | sel_top | sel_gate | sel_ctrl2 |
                  sel_status | sel_istat | sel_imask;
   wire wr_ctrl1 = wr_fire & sel_ctrl1;
   wire wr_low = wr_fire & sel_low;
   wire wr_mid = wr_fire & sel_mid;
   wire wr_top = wr_fire & sel_top;
   wire clear_req = wr_ctrl1 & ~pwdata[`WTC_CLR_BIT];
   wire [7:0] status_byte = {4'h0, armed_reg, gate_level, running, ovf_reg};

   always_comb begin
      rdata = 32'h0000_0000;
      if (sel_ctrl1) begin
         rdata[7:0] = {1'b1, run_reg, src_reg, mode_reg};
      end else if (sel_low) begin
         rdata[7:0] = cnt_reg[7:0];
      end else if (sel_mid) begin
         rdata[7:0] = cnt_reg[15:8];
      end else if (sel_top) begin
         rdata[`WTC_TOP_USED-1:0] = cnt_reg[17:16];
      end else if (sel_gate) begin
         rdata[7:0] = gate_reg;
      end else if (sel_ctrl2) begin
         rdata[3:0] = ctrl2_reg;
      end else if (sel_status) begin
         rdata[7:0] = status_byte;
      end else if (sel_istat) begin
         rdata[`WTC_IRQ_W-1:0] = irq_stat_reg;
      end else if (sel_imask) begin
         rdata[`WTC_IRQ_W-1:0] = irq_mask_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= access_start;
         pslverr_reg <= access_start & ~addr_ok;
         if (access_start) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : rdata;
         end
      end
   end

   // ----------------------------------------
   // Control and setting registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_reg <= 2'(`WTC_CTRL1_RST >> `WTC_RUN_LO);
         src_reg <= 3'b000;
         mode_reg <= 2'b00;
         ctrl2_reg <= `WTC_CTRL2_RST;
         gate_reg <= `WTC_GATE_RST;
         irq_mask_reg <= '0;
      end else if (wr_fire) begin
         if (sel_ctrl1) begin
            run_reg <= pwdata[`WTC_RUN_HI:`WTC_RUN_LO];
            src_reg <= pwdata[`WTC_SRC_HI:`WTC_SRC_LO];
            mode_reg <= pwdata[`WTC_MODE_HI:`WTC_MODE_LO];
         end
         if (sel_ctrl2) begin
            ctrl2_reg <= pwdata[3:0];
         end
         if (sel_gate) begin
            gate_reg <= pwdata[7:0];
         end
         if (sel_imask) begin
            irq_mask_reg <= pwdata[`WTC_IRQ_W-1:0];
         end
      end
   end

   // ----------------------------------------
   // Compare register and its arming
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_reg <= '0;
         armed_reg <= 1'b1;
      end else begin
         if (wr_low) begin
            cmp_reg[7:0] <= pwdata[7:0];
         end
         if (wr_mid) begin
            cmp_reg[15:8] <= pwdata[7:0];
         end
         if (wr_top) begin
            cmp_reg[17:16] <= pwdata[`WTC_TOP_USED-1:0];
         end
         if (wr_top) begin
            armed_reg <= 1'b1;
         end else if (wr_low | wr_mid) begin
            armed_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Up-counter by operating mode
   // ----------------------------------------
   wire cnt_full = &cnt_reg;
   wire [`WTC_CNT_W-1:0] cnt_inc = cnt_reg + 1'b1;
   wire mode_timer = (wtc_mode_t'(mode_reg) == WTC_MODE_TIMER);
   wire mode_pulse = (wtc_mode_t'(mode_reg) == WTC_MODE_PULSE);

   always_comb begin
      cnt_next = cnt_reg;
      match_evt = 1'b0;
      ovf_evt = 1'b0;
      done_evt = 1'b0;
      if (mode_timer) begin
         if (src_tick) begin
            if (armed_reg && cnt_inc == cmp_reg) begin
               cnt_next = '0;
               match_evt = 1'b1;
            end else begin
               cnt_next = cnt_inc;
               ovf_evt = cnt_full;
            end
         end
      end else if (mode_pulse) begin
         if (ev_rise) begin
            cnt_next = '0;
         end else if (ev_level & src_tick) begin
            cnt_next = cnt_inc;
            ovf_evt = cnt_full;
         end
         done_evt = ev_fall;
      end else if (mode_freq) begin
         if (gate_rise) begin
            cnt_next = '0;
         end else if (gate_level & ev_fall) begin
            cnt_next = cnt_inc;
            ovf_evt = cnt_full;
         end
         done_evt = gate_fall;
      end
      if (!running) begin
         cnt_next = (run_reg == WTC_RUN_STOP) ? '0 : cnt_reg;
         match_evt = 1'b0;
         ovf_evt = 1'b0;
         done_evt = 1'b0;
      end
      if (clear_req) begin
         cnt_next = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
         ovf_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         if (ovf_evt) begin
            ovf_reg <= 1'b1;
         end else if (clear_req) begin
            ovf_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Interrupt status, mask and output
   // ----------------------------------------
   wire [`WTC_IRQ_W-1:0] irq_set = {done_evt, ovf_evt, match_evt};
   wire [`WTC_IRQ_W-1:0] irq_clr = (wr_fire & sel_istat) ? pwdata[`WTC_IRQ_W-1:0] : '0;

   assign irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_reg <= |(irq_stat_next & irq_mask_reg);
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;
endmodule

/* hdl/wtc_defs.svh */
// Register offsets, field positions, reset values and timing counts of the wide counter
`ifndef WTC_DEFS_SVH
`define WTC_DEFS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define WTC_OFF_CTRL1 8'h14
`define WTC_OFF_CMP_LOW 8'h18
`define WTC_OFF_CMP_MID 8'h1C
`define WTC_OFF_CMP_TOP 8'h20
`define WTC_OFF_GATE 8'h24
`define WTC_OFF_CTRL2 8'h28
`define WTC_OFF_STATUS 8'h2C
`define WTC_OFF_IRQ_STAT 8'h30
`define WTC_OFF_IRQ_MASK 8'h34

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WTC_CLR_BIT 7
`define WTC_RUN_HI 6
`define WTC_RUN_LO 5
`define WTC_SRC_HI 4
`define WTC_SRC_LO 2
`define WTC_MODE_HI 1
`define WTC_MODE_LO 0
`define WTC_GSRC_HI 1
`define WTC_GSRC_LO 0
`define WTC_DIVOPT_BIT 2
`define WTC_SLOW_BIT 3
`define WTC_IRQ_MATCH 0
`define WTC_IRQ_OVF 1
`define WTC_IRQ_DONE 2

// ----------------------------------------
// Widths, reset values, counts
// ----------------------------------------
`define WTC_CNT_W 18
`define WTC_TOP_USED 2
`define WTC_CTRL1_RST 8'h00
`define WTC_CTRL2_RST 4'h0
`define WTC_GATE_RST 8'h00
`define WTC_GATE_FULL 5'h10
`define WTC_IRQ_W 3
`define WTC_PRE_W 23

`endif

/* hdl/wtc_pkg.sv */
// Types shared by the wide counter design
package wtc_pkg;
   typedef enum logic [1:0] {
      WTC_RUN_STOP = 2'b00,
      WTC_RUN_START = 2'b10
   } wtc_run_t;

   typedef enum logic [1:0] {
      WTC_MODE_TIMER = 2'b00,
      WTC_MODE_RSVD = 2'b01,
      WTC_MODE_PULSE = 2'b10,
      WTC_MODE_FREQ = 2'b11
   } wtc_mode_t;

   typedef enum logic [1:0] {
      WTC_GATE_IDLE = 2'b00,
      WTC_GATE_HIGH = 2'b01,
      WTC_GATE_LOW = 2'b11
   } wtc_gate_state_t;
endpackage

/* hdl/wtc_prescaler.sv */
// Free running binary prescaler with one-cycle tap pulses
`timescale 1ns/1ps
`include "wtc_defs.svh"
module wtc_prescaler
   import wtc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic step,
   output logic [`WTC_PRE_W:0] tick
);
   logic [`WTC_PRE_W-1:0] count_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_reg <= '0;
      end else if (step) begin
         count_reg <= count_reg + 1'b1;
      end
   end

   // ----------------------------------------
   // Tap n pulses once per 2^n steps
   // ----------------------------------------
   assign tick[0] = step;
   genvar i;
   generate
      for (i = 1; i <= `WTC_PRE_W; i = i + 1) begin : g_tap
         assign tick[i] = step & (&count_reg[i-1:0]);
      end
   endgenerate
endmodule

/* hdl/wtc_gate_gen.sv */
// Window gate pulse generator
`timescale 1ns/1ps
`include "wtc_defs.svh"
module wtc_gate_gen
   import wtc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic tick,
   input wire logic [3:0] high_set,
   input wire logic [3:0] low_set,
   output logic gate
);
   wtc_gate_state_t state_reg;
   wtc_gate_state_t state_next;
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   wire [4:0] high_len = `WTC_GATE_FULL - {1'b0, high_set};
   wire [4:0] low_len = `WTC_GATE_FULL - {1'b0, low_set};

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         WTC_GATE_IDLE: begin
            state_next = WTC_GATE_HIGH;
            cnt_next = high_len;
         end
         WTC_GATE_HIGH: begin
            if (tick) begin
               cnt_next = cnt_reg - 5'd1;
               if (cnt_reg == 5'd1) begin
                  state_next = WTC_GATE_LOW;
                  cnt_next = low_len;
               end
            end
         end
         WTC_GATE_LOW: begin
            if (tick) begin
               cnt_next = cnt_reg - 5'd1;
               if (cnt_reg == 5'd1) begin
                  state_next = WTC_GATE_HIGH;
                  cnt_next = high_len;
               end
            end
         end
         default: begin
            state_next = WTC_GATE_IDLE;
            cnt_next = 5'd0;
         end
      endcase
      if (!enable) begin
         state_next = WTC_GATE_IDLE;
         cnt_next = 5'd0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= WTC_GATE_IDLE;
         cnt_reg <= 5'd0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   assign gate = (state_reg == WTC_GATE_HIGH);
endmodule

/* tb/wtc_checker.sv */
// Port assertions for the wide counter register bus
`timescale 1ns/1ps
module wtc_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic low_freq_clock_pin,
   input wire logic event_pin,
   input wire logic irq
);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   logic [7:0] gate_shadow_reg;
   wire map_hit = paddr inside {8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34};
   wire done_rd = pready && !pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_shadow_reg <= 8'h00;
      end else if (pready && pwrite && paddr == 8'h24) begin
         gate_shadow_reg <= pwdata[7:0];
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   ready_after_access_a: assert property (psel && penable && !pready && !$past(penable) |=> pready)
      else $error("pready missing after access cycle");
   ready_one_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   err_unmapped_a: assert property (pready && !map_hit |-> pslverr && (pwrite || prdata == 32'h0000_0000))
      else $error("unmapped access not refused");
   no_err_mapped_a: assert property (pready && map_hit |-> !pslverr)
      else $error("mapped access refused");
   top_bits_zero_a: assert property (done_rd && paddr == 8'h20 |-> prdata[31:2] == 30'h0000_0000)
      else $error("top compare byte upper bits not zero");
   clear_reads_one_a: assert property (done_rd && paddr == 8'h14 |-> prdata[7])
      else $error("clear bit not read as one");
   gate_readback_a: assert property (done_rd && paddr == 8'h24 |-> prdata[7:0] == gate_shadow_reg)
      else $error("gate register readback wrong");
endmodule

bind wtc_top wtc_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .low_freq_clock_pin(low_freq_clock_pin), .event_pin(event_pin), .irq(irq));

/* tb/wtc_top_tb.sv */
// Self-checking testbench for the wide counter
`timescale 1ns/1ps
module wtc_top_tb;
   import wtc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic low_freq_clock_pin = 1'b0;
   logic event_pin = 1'b1;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic [31:0] rdat;
   logic rerr;
   logic [31:0] held;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [7:0] row_a [6] = '{8'h24, 8'h24, 8'h28, 8'h34, 8'h28, 8'h34};
   logic [31:0] row_d [6] = '{32'h0000_00A5, 32'h0000_000F, 32'h0000_0005, 32'h0000_0007, 32'h0000_0000,
      32'h0000_0000};

   wtc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .low_freq_clock_pin(low_freq_clock_pin), .event_pin(event_pin), .irq(irq));

   // ----------------------------------------
   // Clock, slow clock pin, timeout
   // ----------------------------------------
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   // Slow clock pin: period of 32 pclk cycles
   always begin
      repeat (16) @(posedge pclk);
      low_freq_clock_pin <= ~low_freq_clock_pin;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) mismatches++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic wait_irq(input logic lvl);
      int n;
      n = 0;
      while (irq !== lvl && n < 1200) begin
         @(negedge pclk);
         n++;
      end
      check({31'h0000_0000, irq}, {31'h0000_0000, lvl}, "irq level");
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h14);
      check(rdat, 32'h0000_0080, "control one reset");
      rd(8'h24);
      check(rdat, 32'h0000_0000, "gate reset");
      rd(8'h18);
      check(rdat, 32'h0000_0000, "count reset");
      $display("test reset values done");
      for (int i = 0; i < 6; i++) begin
         wr(row_a[i], row_d[i]);
         rd(row_a[i]);
         check(rdat, row_d[i], "register row");
      end
      for (int i = 0; i < 32; i++) begin
         wr(8'h14, 32'h0000_0080 | 32'(i));
         rd(8'h14);
         check(rdat, 32'h0000_0080 | 32'(i), "source and mode codes");
      end
      wr(8'h14, 32'h0000_0080);
      $display("test register table done");
      wr(8'h3C, 32'h0000_0001);
      check({31'h0000_0000, rerr}, 32'h0000_0001, "unmapped write");
      rd(8'h3C);
      check(rdat, 32'h0000_0000, "unmapped read");
      $display("test unmapped done");
      wr(8'h18, 32'h0000_0005);
      rd(8'h2C);
      check(rdat & 32'h0000_0008, 32'h0000_0000, "compare disarmed");
      wr(8'h1C, 32'h0000_0000);
      wr(8'h20, 32'h0000_0000);
      rd(8'h2C);
      check(rdat & 32'h0000_0008, 32'h0000_0008, "compare armed");
      $display("test compare arming done");
      wr(8'h28, 32'h0000_0008);
      wr(8'h34, 32'h0000_0001);
      wr(8'h14, 32'h0000_00C0);
      wait_irq(1'b1);
      wr(8'h34, 32'h0000_0000);
      wait_irq(1'b0);
      wr(8'h34, 32'h0000_0001);
      wait_irq(1'b1);
      wr(8'h14, 32'h0000_0080);
      rd(8'h30);
      check(rdat & 32'h0000_0001, 32'h0000_0001, "match status");
      wr(8'h30, 32'h0000_0001);
      wait_irq(1'b0);
      rd(8'h18);
      check(rdat, 32'h0000_0000, "stopped count");
      $display("test timer interrupt done");
      wr(8'h18, 32'h0000_00FF);
      wr(8'h1C, 32'h0000_00FF);
      wr(8'h20, 32'h0000_00FF);
      wr(8'h14, 32'h0000_009C);
      wr(8'h14, 32'h0000_00DC);
      repeat (3) begin
         repeat (4) @(posedge pclk);
         event_pin <= 1'b0;
         repeat (4) @(posedge pclk);
         event_pin <= 1'b1;
      end
      repeat (6) @(posedge pclk);
      rd(8'h18);
      check(rdat, 32'h0000_0003, "event count");
      $display("test event counter done");
      // No events now, so the running count stands still
      held = rdat;
      check({31'h0000_0000, held == 32'h0000_0000}, 32'h0000_0000, "count advanced");
      rd(8'h20);
      check(rdat & 32'hFFFF_FFFC, 32'h0000_0000, "top byte upper bits");
      rd(8'h18);
      check(rdat, held, "held count stable");
      wr(8'h14, 32'h0000_005C);
      rd(8'h18);
      check(rdat, 32'h0000_0000, "cleared count");
      rd(8'h14);
      check(rdat, 32'h0000_00DC, "clear bit returns");
      wr(8'h14, 32'h0000_0080);
      $display("test hold and clear done");
      // Gate 1 + 1 ticks of 16 slow periods, 32 pclk each
      wr(8'h24, 32'h0000_00FF);
      wr(8'h34, 32'h0000_0004);
      wr(8'h14, 32'h0000_009F);
      wr(8'h14, 32'h0000_00DF);
      wait_irq(1'b1);
      held = cycles;
      wr(8'h30, 32'h0000_0004);
      wait_irq(1'b0);
      wait_irq(1'b1);
      check(cycles - held, 32'd1024, "gate period");
      wr(8'h14, 32'h0000_0080);
      $display("test window gate done");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h14);
      check(rdat, 32'h0000_0080, "control one after reset");
      check({31'h0000_0000, irq}, 32'h0000_0000, "irq after reset");
      $display("test second reset done");
      tally_and_finish();
   end
endmodule
